// File: logic/dcr_chan_bank.v
// one channel's base, offset and count storage
`timescale 1ns/1ps
`include "dcr_defines.vh"
module dcr_chan_bank (
    // clock and reset
    input wire clk,
    input wire srst,
    // write port
    input wire wrEn,
    input wire [7:0] wrAddr,
    input wire [7:0] wrData,
    // byte moved by this channel
    input wire step,
    // stored state
    output reg [`DCR_BASE_W-1:0] base_q,
    output reg [`DCR_AOFS_W-1:0] aofs_q,
    output reg [`DCR_CNT_W-1:0] cnt_q
);
    always @(posedge clk) begin
        if (srst) begin
            base_q <= {`DCR_BASE_W{1'b0}};
            aofs_q <= {`DCR_AOFS_W{1'b0}};
            cnt_q <= {`DCR_CNT_W{1'b0}};
        end else begin
            if (wrEn) begin
                case (wrAddr)
                    `DCR_OFS_BASE_LO: base_q[7:0] <= wrData;
                    `DCR_OFS_BASE_HI: base_q[11:8] <= wrData[3:0];
                    `DCR_OFS_CNT_LO: cnt_q[7:0] <= wrData;
                    `DCR_OFS_CNT_HI: cnt_q[9:8] <= wrData[1:0];
                    default: begin
                    end
                endcase
            end
            // offset halves written; software write beats a step
            if (wrEn && wrAddr == `DCR_OFS_AOFS_LO) begin
                aofs_q[7:0] <= wrData;
            end else if (wrEn && wrAddr == `DCR_OFS_AOFS_HI) begin
                aofs_q[9:8] <= wrData[1:0];
            end else if (step) begin
                aofs_q <= aofs_q + 10'h001;
            end
        end
    end
endmodule

// File: logic/dcr_defines.vh
// register offsets, field layouts, reset values and a summary of operation
// Summary of operation
// - each channel keeps a 4-bit base upper field in bits 3:0, rest reserved
// - each channel keeps an 8-bit base lower field in bits 7:0
// - current memory address is channel base plus its present offset
// - offset steps up by one after each byte a channel moves
// - 10-bit offset, upper 2 bits in bits 1:0, both halves writable
// - with offset zero the first address used is exactly the base
// - transfer count upper 2 bits sit in bits 1:0, rest reserved
// - transfer count lower 8 bits sit in bits 7:0, 10 bits total
// - all fields banked per channel, access reaches selected channel only
`ifndef DCR_DEFINES_VH
`define DCR_DEFINES_VH
`define DCR_OFS_BASE_LO 8'hC9
`define DCR_OFS_BASE_HI 8'hCA
`define DCR_OFS_AOFS_LO 8'hCB
`define DCR_OFS_AOFS_HI 8'hCC
`define DCR_OFS_CNT_LO 8'hCD
`define DCR_OFS_CNT_HI 8'hCE
`define DCR_BASE_HI_W 4
`define DCR_AOFS_HI_W 2
`define DCR_CNT_HI_W 2
`define DCR_BASE_W 12
`define DCR_AOFS_W 10
`define DCR_CNT_W 10
`define DCR_RESET_BYTE 8'h00
`define DCR_FIFO_DEPTH 32
`endif

// File: logic/dcr_fifo.v
// synchronous fifo carrying the formed memory addresses
`timescale 1ns/1ps
module dcr_fifo #(
    parameter WIDTH = 12,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    // clock and reset
    input wire clk,
    input wire srst,
    // fill side
    input wire inValid,
    output wire inReady,
    input wire [WIDTH-1:0] inData,
    // drain side
    output wire outValid,
    input wire outReady,
    output reg [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wrPtr_q;
    reg [AW-1:0] rdPtr_q;
    reg [AW:0] level_q;
    reg outValid_q;
    wire doWrite;
    wire doRead;
    wire memHas;

    assign inReady = (level_q != DEPTH[AW:0]);
    assign memHas = (level_q != {(AW+1){1'b0}});
    assign outValid = outValid_q;
    // output register reloads when empty or consumed
    assign doRead = memHas && (!outValid_q || outReady);
    assign doWrite = inValid && inReady;

    always @(posedge clk) begin
        if (doWrite) begin
            mem[wrPtr_q] <= inData;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            wrPtr_q <= {AW{1'b0}};
            rdPtr_q <= {AW{1'b0}};
            level_q <= {(AW+1){1'b0}};
            outValid_q <= 1'b0;
            outData <= {WIDTH{1'b0}};
        end else begin
            if (doWrite) begin
                wrPtr_q <= wrPtr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (doRead) begin
                rdPtr_q <= rdPtr_q + {{(AW-1){1'b0}}, 1'b1};
                outData <= mem[rdPtr_q];
                outValid_q <= 1'b1;
            end else if (outReady) begin
                outValid_q <= 1'b0;
            end
            if (doWrite && !doRead) begin
                level_q <= level_q + {{AW{1'b0}}, 1'b1};
            end else if (!doWrite && doRead) begin
                level_q <= level_q - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule

// File: logic/dcr_regs.v
// banked per-channel base, offset and count registers with address stream
`timescale 1ns/1ps
`include "dcr_defines.vh"
module dcr_regs #(
    parameter NCHAN = 7,
    parameter SELW = 3,
    parameter FIFO_DEPTH = `DCR_FIFO_DEPTH,
    parameter FIFO_AW = 5
) (
    // clock and reset
    input wire clk,
    input wire srst,
    // special function register access
    input wire [SELW-1:0] channelSelect,
    input wire [7:0] sfrAddr,
    input wire sfrWrite,
    input wire [7:0] sfrWrData,
    output reg [7:0] sfrRdData,
    output wire sfrHit,
    // byte movement requests
    input wire moveValid,
    input wire [SELW-1:0] moveChannel,
    output wire moveReady,
    // formed data memory addresses
    output wire addrValid,
    input wire addrReady,
    output wire [`DCR_BASE_W-1:0] addrOut
);
    ////////////////////////////////////////////////////////////////////////
    wire [`DCR_BASE_W*NCHAN-1:0] baseAll;
    wire [`DCR_AOFS_W*NCHAN-1:0] aofsAll;
    wire [`DCR_CNT_W*NCHAN-1:0] cntAll;
    wire [`DCR_BASE_W-1:0] selBase;
    wire [`DCR_AOFS_W-1:0] selAofs;
    wire [`DCR_CNT_W-1:0] selCnt;
    wire [`DCR_BASE_W-1:0] mvBase;
    wire [`DCR_AOFS_W-1:0] mvAofs;
    wire [`DCR_BASE_W-1:0] curAddr;
    wire moveTake;

    function isMine;
        input [7:0] a;
        begin
            isMine = (a >= `DCR_OFS_BASE_LO) && (a <= `DCR_OFS_CNT_HI);
        end
    endfunction

    assign sfrHit = isMine(sfrAddr);
    // stepping stalls when address fifo is full
    assign moveTake = moveValid && moveReady && (moveChannel < NCHAN[SELW-1:0]);

    ////////////////////////////////////////////////////////////////////////
    genvar g;
    generate
        for (g = 0; g < NCHAN; g = g + 1) begin : gBank
            dcr_chan_bank uBank (
                .clk(clk),
                .srst(srst),
                .wrEn(sfrWrite && isMine(sfrAddr) && channelSelect == g),
                .wrAddr(sfrAddr),
                .wrData(sfrWrData),
                .step(moveTake && moveChannel == g),
                .base_q(baseAll[g*`DCR_BASE_W +: `DCR_BASE_W]),
                .aofs_q(aofsAll[g*`DCR_AOFS_W +: `DCR_AOFS_W]),
                .cnt_q(cntAll[g*`DCR_CNT_W +: `DCR_CNT_W])
            );
        end
    endgenerate

    assign selBase = baseAll[channelSelect*`DCR_BASE_W +: `DCR_BASE_W];
    assign selAofs = aofsAll[channelSelect*`DCR_AOFS_W +: `DCR_AOFS_W];
    assign selCnt = cntAll[channelSelect*`DCR_CNT_W +: `DCR_CNT_W];

    always @* begin
        sfrRdData = `DCR_RESET_BYTE;
        if (channelSelect < NCHAN[SELW-1:0]) begin
            case (sfrAddr)
                `DCR_OFS_BASE_LO: sfrRdData = selBase[7:0];
                `DCR_OFS_BASE_HI: sfrRdData = {4'h0, selBase[11:8]};
                `DCR_OFS_AOFS_LO: sfrRdData = selAofs[7:0];
                `DCR_OFS_AOFS_HI: sfrRdData = {6'h00, selAofs[9:8]};
                `DCR_OFS_CNT_LO: sfrRdData = selCnt[7:0];
                `DCR_OFS_CNT_HI: sfrRdData = {6'h00, selCnt[9:8]};
                default: sfrRdData = `DCR_RESET_BYTE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign mvBase = baseAll[moveChannel*`DCR_BASE_W +: `DCR_BASE_W];
    assign mvAofs = aofsAll[moveChannel*`DCR_AOFS_W +: `DCR_AOFS_W];
    // base plus offset; zero offset gives base
    assign curAddr = mvBase + {2'b00, mvAofs};

    dcr_fifo #(
        .WIDTH(`DCR_BASE_W),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) uFifo (
        .clk(clk),
        .srst(srst),
        .inValid(moveValid && (moveChannel < NCHAN[SELW-1:0])),
        .inReady(moveReady),
        .inData(curAddr),
        .outValid(addrValid),
        .outReady(addrReady),
        .outData(addrOut)
    );
endmodule

// File: tb/dcr_mem_model.sv
// address consumer standing in for data memory
`timescale 1ns/1ps
module dcr_mem_model (
    // clock and reset
    input wire clk,
    input wire srst,
    // stall control
    input wire slow,
    // address stream
    output wire addrReady
);
reg [1:0] gap_q;
// busy three cycles in four when slow, so the buffer backs up
always @(posedge clk) begin
    gap_q <= srst ? 2'h0 : gap_q + 2'h1;
end
assign addrReady = !slow || gap_q == 2'h3;
endmodule

// File: tb/dcr_regs_checker.sv
// checker for the banked dma address register block
`timescale 1ns/1ps
module dcr_regs_checker #(
    parameter NCHAN = 7,
    parameter SELW = 3
) (
    // clock and reset
    input wire clk,
    input wire srst,
    // register access
    input wire [SELW-1:0] channelSelect,
    input wire [7:0] sfrAddr,
    input wire sfrWrite,
    input wire [7:0] sfrWrData,
    input wire [7:0] sfrRdData,
    input wire sfrHit,
    // address stream
    input wire moveValid,
    input wire [SELW-1:0] moveChannel,
    input wire moveReady,
    input wire addrValid,
    input wire addrReady,
    input wire [11:0] addrOut
);
default clocking @(posedge clk); endclocking
default disable iff (srst);
////////
wire [7:0] mask = sfrAddr == 8'hCA ? 8'h0F : (sfrAddr == 8'hCC || sfrAddr == 8'hCE) ? 8'h03 : 8'hFF;
sequence s_write;
    sfrWrite && sfrHit && channelSelect < NCHAN;
endsequence
sequence s_take;
    moveValid && moveReady && moveChannel < NCHAN;
endsequence
a_reset_clean: assert property ($past(srst) |-> !addrValid && moveReady && sfrRdData == 8'h00)
    else $error("state not clear after reset");
a_hit_decode: assert property (sfrHit == (sfrAddr >= 8'hC9 && sfrAddr <= 8'hCE))
    else $error("hit decode wrong");
a_base_resv: assert property (sfrAddr == 8'hCA |-> sfrRdData[7:4] == 4'h0)
    else $error("base upper reserved bits set");
a_upper_resv: assert property ((sfrAddr == 8'hCC || sfrAddr == 8'hCE) |-> sfrRdData[7:2] == 6'h00)
    else $error("upper reserved bits set");
a_write_back: assert property (s_write ##1 ($stable(sfrAddr) && $stable(channelSelect))
    |-> sfrRdData == ($past(sfrWrData) & mask)) else $error("written value not read back");
a_bad_chan: assert property (channelSelect >= NCHAN |-> sfrRdData == 8'h00)
    else $error("absent channel reads nonzero");
a_addr_hold: assert property (addrValid && !addrReady |=> addrValid && $stable(addrOut))
    else $error("address dropped while stalled");
a_first_addr: assert property (!addrValid ##0 s_take |-> ##2 addrValid)
    else $error("address late after move");
endmodule
bind dcr_regs dcr_regs_checker #(.NCHAN(NCHAN), .SELW(SELW)) chk (.*);

// File: tb/tb_top.sv
// random and corner stimulus for the dma address registers
`timescale 1ns/1ps
module tb_top;
reg clk = 0, srst = 1, sfrWrite = 0, moveValid = 0, slow = 0;
reg [2:0] channelSelect = 0, moveChannel = 0;
reg [7:0] sfrAddr = 0, sfrWrData = 0;
wire [7:0] sfrRdData;
wire [11:0] addrOut;
wire sfrHit, moveReady, addrValid, addrReady;
reg [11:0] bs [0:6], q [$];
reg [9:0] ofs [0:6], cn [0:6];
reg [31:0] rs = 32'h107CE31F;
int bad_count = 0, cmp_count = 0, c, i, n;
always #12.5 clk = ~clk;
dcr_regs dut (.*);
dcr_mem_model mem (.*);
////////
function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
endfunction
function [7:0] ev(input int k, input [7:0] a);
    reg [11:0] v;
    v = a < 8'hCB ? bs[k] : a < 8'hCD ? {2'h0, ofs[k]} : {2'h0, cn[k]};
    ev = a[0] ? v[7:0] : {4'h0, v[11:8]};
endfunction
task automatic chk(input logic [11:0] g, input logic [11:0] e);
    cmp_count++;
    if (g !== e) begin
        bad_count++;
        $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
endtask
task wr(input [2:0] k, input [7:0] a, input [7:0] d);
    channelSelect <= k;
    sfrAddr <= a;
    sfrWrData <= d;
    sfrWrite <= 1'b1;
    @(posedge clk);
    sfrWrite <= 1'b0;
    @(posedge clk);
endtask
task rd(input [2:0] k, input [7:0] a, input [7:0] e);
    channelSelect <= k;
    sfrAddr <= a;
    @(negedge clk);
    chk({4'h0, sfrRdData}, {4'h0, e});
    @(posedge clk);
endtask
task allrd;
    for (c = 0; c < 7; c++)
        for (i = 8'hC9; i < 8'hCF; i++) rd(3'(c), 8'(i), ev(c, 8'(i)));
endtask
// moves are held until taken; full buffer refuses
task mv(input [2:0] k);
    moveValid <= 1'b1;
    moveChannel <= k;
    n = 0;
    @(negedge clk);
    while (moveReady !== 1'b1 && n < 300) begin
        @(negedge clk);
        n++;
    end
    if (n >= 300) bad_count++;
    @(posedge clk);
    q.push_back(bs[k] + {2'h0, ofs[k]});
    ofs[k] = ofs[k] + 10'h001;
endtask
task tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
        $display("Finished cleanly");
    else
        $display("Finished with errors");
    $finish;
endtask
////////
always @(posedge clk) if (addrValid === 1'b1 && addrReady === 1'b1) chk(addrOut, q.pop_front());
initial begin
    #200000;
    bad_count++;
    tally_and_finish;
end
initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    for (c = 0; c < 7; c++) begin
        bs[c] = 0;
        ofs[c] = 0;
        cn[c] = 0;
    end
    allrd;
    for (c = 0; c < 7; c++) begin
        rs = lfsr(rs);
        bs[c] = rs[11:0];
        ofs[c] = c < 4 ? 10'h000 : rs[21:12];
        cn[c] = rs[31:22];
    end
    // wrap corner for both sum and offset
    bs[6] = 12'hFFF;
    ofs[6] = 10'h3FF;
    for (c = 0; c < 7; c++)
        for (i = 8'hC9; i < 8'hCF; i++) wr(3'(c), 8'(i), ev(c, 8'(i)));
    wr(3'h7, 8'hCA, 8'h0F);
    allrd;
    rd(3'h7, 8'hCA, 8'h00);
    rd(3'h0, 8'hC8, 8'h00);
    slow <= 1'b1;
    for (i = 0; i < 70; i++) begin
        rs = lfsr(rs);
        mv(3'(rs % 7));
    end
    moveValid <= 1'b0;
    slow <= 1'b0;
    n = 0;
    while (q.size() != 0 && n < 200) begin
        @(negedge clk);
        n++;
    end
    chk(12'(q.size()), 12'h000);
    @(posedge clk);
    allrd;
    tally_and_finish;
end
endmodule
